// file: logic/abr_top.sv
// serial bus slave with own-address and self-clearing soft reset registers
`timescale 1ns/1ps
`include "abr_regs.svh"
module abr_top #(
    parameter int RST_CYC = `ABR_RST_PULSE_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // serial bus pins, open drain data
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    // decoded address strap
    input wire logic [6:0] i_addr_strap,
    // resets toward the chip and restore strobe for other banks
    output abr_pkg::abr_rst_t o_rst,
    output logic o_restore
);
    // refuse pulse lengths that the five-bit counters cannot hold
    if (RST_CYC < 1 || RST_CYC > 31) begin : g_bad_rst_cyc
        $error("RST_CYC out of range");
    end

    // two-flop synchronisers, third stage only for edge detection
    logic [2:0] scl_s_q, sda_s_q;
    logic [6:0] strap_m_q, strap_s_q;
    always_ff @(posedge i_clk) begin
        scl_s_q <= {scl_s_q[1:0], i_scl};
        sda_s_q <= {sda_s_q[1:0], i_sda};
        strap_m_q <= i_addr_strap;
        strap_s_q <= strap_m_q;
    end
    wire scl_rise = scl_s_q[1] & ~scl_s_q[2];
    wire scl_fall = ~scl_s_q[1] & scl_s_q[2];
    wire bus_start = scl_s_q[1] & ~sda_s_q[1] & sda_s_q[2];
    wire bus_stop = scl_s_q[1] & sda_s_q[1] & ~sda_s_q[2];
    wire sda_in = sda_s_q[1];

    // slave and register state
    abr_pkg::abr_state_t st_q, st_d;
    logic [7:0] sh_q, sh_d;       // shift register for both directions
    logic [3:0] bit_q, bit_d;     // bits seen in current byte
    logic rw_q, rw_d;             // read request latched from address byte
    logic [7:0] ptr_q, ptr_d;     // register pointer
    logic oe_q, oe_d;             // pulls data low when high
    logic [6:0] prog_q, prog_d;   // programmed bus address field
    logic sel_q, sel_d;           // address source select
    logic [6:0] strap_q, strap_d; // strap address latched at boot
    logic load_q, load_d;         // strap reload request
    logic restore_q, restore_d;   // restore strobe to other banks
    logic [2:0] rst_go;           // write of 1 to a reset bit, one cycle
    abr_pkg::abr_rst_t rst_q;     // reset bit states, also read back
    logic full_end;               // last cycle of full reset

    // address the slave answers at
    wire [6:0] own_addr = sel_q ? prog_q : strap_q;
    // read data mux, reserved bits and unmapped offsets read zero
    logic [7:0] rd_data;
    always_comb begin
        rd_data = 8'h00;
        if (ptr_q == `ABR_OFF_ADDR) begin
            rd_data = {prog_q, sel_q};
        end else if (ptr_q == `ABR_OFF_RST) begin
            rd_data[`ABR_RST_VIDEO_BIT] = rst_q.video;
            rd_data[`ABR_RST_FULL_BIT] = rst_q.full;
            rd_data[`ABR_RST_KEEP_BIT] = rst_q.keep;
        end
    end

    // bus slave next state plus register writes and restores
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        bit_d = bit_q;
        rw_d = rw_q;
        ptr_d = ptr_q;
        oe_d = oe_q;
        prog_d = prog_q;
        sel_d = sel_q;
        strap_d = strap_q;
        load_d = 1'b0;
        restore_d = 1'b0;
        rst_go = 3'b000;
        if (bus_start) begin
            st_d = abr_pkg::ABR_ADDR;
            bit_d = 4'h0;
            oe_d = 1'b0;
        end else if (bus_stop) begin
            st_d = abr_pkg::ABR_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                abr_pkg::ABR_ADDR, abr_pkg::ABR_WOFF, abr_pkg::ABR_WDAT: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_in};
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        bit_d = 4'h0;
                        oe_d = 1'b1;
                        if (st_q == abr_pkg::ABR_ADDR) begin
                            rw_d = sh_q[0];
                            if (sh_q[7:1] == own_addr) begin
                                st_d = abr_pkg::ABR_ACKA;
                            end else begin
                                st_d = abr_pkg::ABR_IDLE;
                                oe_d = 1'b0;
                            end
                        end else if (st_q == abr_pkg::ABR_WOFF) begin
                            ptr_d = sh_q;
                            st_d = abr_pkg::ABR_ACKO;
                        end else begin
                            st_d = abr_pkg::ABR_ACKD;
                            ptr_d = ptr_q + 8'h01;
                            if (ptr_q == `ABR_OFF_ADDR) begin
                                prog_d = sh_q[7:1];
                                sel_d = sh_q[`ABR_ADDR_SEL_BIT];
                            end else if (ptr_q == `ABR_OFF_RST) begin
                                rst_go[2] = sh_q[`ABR_RST_VIDEO_BIT];
                                rst_go[1] = sh_q[`ABR_RST_FULL_BIT];
                                rst_go[0] = sh_q[`ABR_RST_KEEP_BIT];
                            end
                        end
                    end
                end
                abr_pkg::ABR_ACKA, abr_pkg::ABR_ACKO, abr_pkg::ABR_ACKD: begin
                    // release after the ack clock, then load read data if asked
                    if (scl_fall) begin
                        bit_d = 4'h0;
                        if (st_q == abr_pkg::ABR_ACKA && rw_q) begin
                            st_d = abr_pkg::ABR_RDAT;
                            sh_d = rd_data;
                            oe_d = ~rd_data[7];
                        end else begin
                            st_d = (st_q == abr_pkg::ABR_ACKA) ? abr_pkg::ABR_WOFF
                                                                : abr_pkg::ABR_WDAT;
                            oe_d = 1'b0;
                        end
                    end
                end
                abr_pkg::ABR_RDAT: begin
                    if (scl_rise) begin
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_q == 4'h8) begin
                            st_d = abr_pkg::ABR_RACK;
                            oe_d = 1'b0;
                            ptr_d = ptr_q + 8'h01;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = ~sh_q[6];
                        end
                    end
                end
                abr_pkg::ABR_RACK: begin
                    // master nack ends the read, ack fetches the next byte
                    if (scl_rise && sda_in) begin
                        st_d = abr_pkg::ABR_IDLE;
                    end else if (scl_fall) begin
                        st_d = abr_pkg::ABR_RDAT;
                        bit_d = 4'h0;
                        sh_d = rd_data;
                        oe_d = ~rd_data[7];
                    end
                end
                default: begin
                    oe_d = 1'b0;
                end
            endcase
        end
        // keep-registers reset and the end of a full reset restore the address bank and strap values
        if (rst_go[0] || full_end) begin
            prog_d = strap_s_q;
            sel_d = `ABR_ADDR_SEL_RST;
            load_d = 1'b1;
            restore_d = 1'b1;
        end
        if (load_q) begin
            strap_d = strap_s_q;
            prog_d = strap_s_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_q <= abr_pkg::ABR_IDLE;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            rw_q <= 1'b0;
            ptr_q <= 8'h00;
            oe_q <= 1'b0;
            prog_q <= 7'h00;
            sel_q <= `ABR_ADDR_SEL_RST;
            strap_q <= 7'h00;
            load_q <= 1'b1; // strap caught in the first cycle after release
            restore_q <= 1'b0;
        end else begin
            st_q <= st_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            rw_q <= rw_d;
            ptr_q <= ptr_d;
            oe_q <= oe_d;
            prog_q <= prog_d;
            sel_q <= sel_d;
            strap_q <= strap_d;
            load_q <= load_d;
            restore_q <= restore_d;
        end
    end

    // one self-clearing pulse counter per reset bit
    logic [2:0] rst_on;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_rst
            logic [4:0] cnt_q, cnt_d;
            always_comb begin
                cnt_d = cnt_q;
                if (rst_go[gi]) begin
                    cnt_d = 5'(RST_CYC);
                end else if (cnt_q != 5'h00) begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    cnt_q <= 5'h00;
                end else begin
                    cnt_q <= cnt_d;
                end
            end
            assign rst_on[gi] = (cnt_d != 5'h00);
        end
    endgenerate
    assign full_end = (g_rst[1].cnt_q == 5'h01);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rst_q <= '0;
        end else begin
            rst_q <= {rst_on[2], rst_on[1], rst_on[0]};
        end
    end

    assign o_sda_o = 1'b0;
    assign o_sda_oe = oe_q;
    assign o_rst = rst_q;
    assign o_restore = restore_q;

    // assertions
    property p_ack_on_match;
        @(posedge i_clk) disable iff (!i_rst_n)
        (st_q == abr_pkg::ABR_ADDR && scl_fall && bit_q == 4'h8 && !bus_start && !bus_stop
         && sh_q[7:1] == own_addr) |=> (st_q == abr_pkg::ABR_ACKA && o_sda_oe);
    endproperty
    a_ack_on_match: assert property (p_ack_on_match) else $error("no ack on match");
    property p_nack_on_miss;
        @(posedge i_clk) disable iff (!i_rst_n)
        (st_q == abr_pkg::ABR_ADDR && scl_fall && bit_q == 4'h8 && !bus_start && !bus_stop
         && sh_q[7:1] != own_addr) |=> (st_q == abr_pkg::ABR_IDLE && !o_sda_oe);
    endproperty
    a_nack_on_miss: assert property (p_nack_on_miss) else $error("ack on mismatch");
    property p_strap_source;
        @(posedge i_clk) disable iff (!i_rst_n)
        !sel_q |-> own_addr == strap_q;
    endproperty
    a_strap_source: assert property (p_strap_source) else $error("bad addr source");
    logic [4:0] vid_len_q, vid_len_d; // cycles the video reset has stood so far
    always_comb vid_len_d = o_rst.video ? vid_len_q + 5'h01 : 5'h00;
    always_ff @(posedge i_clk) vid_len_q <= i_rst_n ? vid_len_d : 5'h00;
    property p_video_hold;
        @(posedge i_clk) disable iff (!i_rst_n)
        $fell(o_rst.video) |-> (vid_len_q == 5'(RST_CYC));
    endproperty
    a_video_hold: assert property (p_video_hold) else $error("bad video reset");
    property p_self_clear;
        @(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_rst.full) |-> ##[1:40] !o_rst.full;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("reset never clears");
    property p_full_restore;
        @(posedge i_clk) disable iff (!i_rst_n)
        $fell(o_rst.full) |-> (!sel_q && o_restore);
    endproperty
    a_full_restore: assert property (p_full_restore) else $error("regs not restored");
    property p_keep_restore;
        @(posedge i_clk) disable iff (!i_rst_n)
        rst_go[0] |=> (!sel_q && o_restore && o_rst.keep) ##2 (prog_q == strap_q);
    endproperty
    a_keep_restore: assert property (p_keep_restore) else $error("keep left regs");
    property p_reserved_zero;
        @(posedge i_clk) disable iff (!i_rst_n)
        (ptr_q == `ABR_OFF_RST) |-> (rd_data[7:5] == 3'h0 && rd_data[3:2] == 2'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");
    property p_boot_strap;
        @(posedge i_clk) $rose(i_rst_n) |=> (prog_q == $past(strap_s_q));
    endproperty
    a_boot_strap: assert property (p_boot_strap) else $error("strap not loaded");
endmodule : abr_top

// file: logic/abr_regs.svh
// offsets, field positions, reset values and timing counts of the address and soft reset bank
// Contract
// - address field boots with strap-selected address
// - bit 0 picks strap or programmed address
// - bit 4 pulses video input reset, self-clears
// - bit 1 resets everything including registers
// - bit 0 resets logic, registers kept
// - bit 0 reloads strap-loaded register values
// - bit 0 restores address and listed registers
// - matching address acked, mismatch left released
`ifndef ABR_REGS_SVH
`define ABR_REGS_SVH
`define ABR_OFF_ADDR 8'h00
`define ABR_OFF_RST 8'h01
`define ABR_ADDR_SEL_BIT 0
`define ABR_RST_KEEP_BIT 0
`define ABR_RST_FULL_BIT 1
`define ABR_RST_VIDEO_BIT 4
`define ABR_ADDR_SEL_RST 1'b0
`define ABR_RST_REG_RST 8'h00
`define ABR_CLK_NS 100
`define ABR_RST_PULSE_NS 1600
`define ABR_RST_PULSE_CYC ((`ABR_RST_PULSE_NS + `ABR_CLK_NS - 1) / `ABR_CLK_NS)
`endif

// file: logic/abr_pkg.sv
// types shared by the address and soft reset bank
package abr_pkg;
    // serial bus slave states, gray coded along the write path
    typedef enum logic [3:0] {
        ABR_IDLE = 4'h0,
        ABR_ADDR = 4'h1,
        ABR_ACKA = 4'h3,
        ABR_WOFF = 4'h2,
        ABR_ACKO = 4'h6,
        ABR_WDAT = 4'h7,
        ABR_ACKD = 4'h5,
        ABR_RDAT = 4'h4,
        ABR_RACK = 4'hC
    } abr_state_t;
    // reset outputs toward the rest of the chip
    typedef struct packed {
        logic video;
        logic full;
        logic keep;
    } abr_rst_t;
endpackage : abr_pkg

// file: verif/abr_host_model.sv
// host serial bus master model that reaches the address and soft reset bank
`timescale 1ns/1ps
module abr_host_model (
    // pacing clock
    input wire logic i_clk,
    // resolved data line level
    input wire logic i_sda,
    // bus clock and data pull-down enable
    output logic o_scl,
    output logic o_sda_oe
);
    // clocks per bus phase, well above the two-flop sync delay of the slave
    localparam int PH = 5;
    // bus idle at time zero: clock high, data released
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    // wait whole clocks, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    // start: data falls while clock high, also used as the first phase of every access
    task automatic start();
        o_sda_oe = 1'b0;
        tick(PH);
        o_scl = 1'b1;
        tick(PH);
        o_sda_oe = 1'b1;
        tick(PH);
        o_scl = 1'b0;
        tick(PH);
    endtask : start
    // stop: data rises while clock high, bus left released
    task automatic stop();
        o_sda_oe = 1'b1;
        tick(PH);
        o_scl = 1'b1;
        tick(PH);
        o_sda_oe = 1'b0;
        tick(PH);
    endtask : stop
    // one bit; data never moves in the cycle the clock falls, so no false start is seen
    task automatic bit_x(input logic b, output logic r);
        o_sda_oe = ~b;
        tick(PH);
        o_scl = 1'b1;
        tick(PH);
        r = i_sda;
        o_scl = 1'b0;
        tick(2);
    endtask : bit_x
    // eight bits msb first, then the ninth bit given as nb
    task automatic byte_x(input logic [7:0] tx, input logic nb, output logic [7:0] rx,
                          output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], r);
            rx[i] = r;
        end
        bit_x(nb, r);
        ack = ~r;
    endtask : byte_x
    // register write: address with write bit, offset, one data byte
    task automatic wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d,
                      output logic ack);
        logic [7:0] rx;
        logic k;
        start();
        byte_x({a, 1'b0}, 1'b1, rx, ack);
        if (ack) begin
            byte_x(off, 1'b1, rx, k);
            byte_x(d, 1'b1, rx, k);
        end
        stop();
    endtask : wr
    // pointer set: address with write bit and offset only, a data byte would be written
    task automatic set_ptr(input logic [6:0] a, input logic [7:0] off, output logic ack);
        logic [7:0] rx;
        logic k;
        start();
        byte_x({a, 1'b0}, 1'b1, rx, ack);
        if (ack) begin
            byte_x(off, 1'b1, rx, k);
        end
        stop();
    endtask : set_ptr
    // register read: set pointer, stop, then read one byte and end it with a nack
    task automatic rd(input logic [6:0] a, input logic [7:0] off, output logic [7:0] d,
                      output logic ack);
        logic [7:0] rx;
        logic k;
        set_ptr(a, off, ack);
        start();
        byte_x({a, 1'b1}, 1'b1, rx, k);
        ack = ack & k;
        byte_x(8'hFF, 1'b1, d, k);
        stop();
    endtask : rd
    // two-byte read: master acks the first byte so the slave sends the next one, nacks the second
    task automatic rd_pair(input logic [6:0] a, input logic [7:0] off, output logic [7:0] d0,
                           output logic [7:0] d1, output logic ack);
        logic [7:0] rx;
        logic k;
        set_ptr(a, off, ack);
        start();
        byte_x({a, 1'b1}, 1'b1, rx, k);
        ack = ack & k;
        byte_x(8'hFF, 1'b0, d0, k);
        byte_x(8'hFF, 1'b1, d1, k);
        stop();
    endtask : rd_pair
endmodule : abr_host_model

// file: verif/abr_top_tb_top.sv
// self-checking bench for the address and soft reset bank
`timescale 1ns/1ps
module abr_top_tb_top;
    // short reset pulse keeps the run brief
    localparam int RST_CYC = 4;
    localparam logic [6:0] STRAP = 7'h3A;
    localparam logic [6:0] PROG = 7'h6A;
    localparam logic [6:0] BAD = 7'h55;
    // clock, reset, pins
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl;
    logic m_oe;
    wire logic sda;
    logic sda_o;
    logic sda_oe;
    logic [6:0] strap = STRAP;
    abr_pkg::abr_rst_t rst;
    logic restore;
    // bench state
    logic [7:0] d;
    logic [7:0] d2;
    logic ack;
    int n_mismatch = 0;
    int cmp_count = 0;
    int run = 0;
    int w_seen = 0;
    int n_restore = 0;
    logic [2:0] seen = 3'h0;
    // pulled-up open drain data line, low while either party pulls
    assign sda = ~m_oe & ~(sda_oe & ~sda_o);
    always #50 clk = ~clk;
    abr_host_model h (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
    abr_top #(.RST_CYC(RST_CYC)) dut (
        .i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
        .o_sda_oe(sda_oe), .i_addr_strap(strap), .o_rst(rst), .o_restore(restore)
    );
    // reset pulse monitor, sampled mid-cycle where registered outputs have settled
    always @(negedge clk) begin
        if (rst !== 3'h0) begin
            run++;
            seen = seen | rst;
        end else if (run != 0) begin
            w_seen = run;
            run = 0;
        end
        if (restore === 1'b1) n_restore++;
    end
    // byte or flag comparison
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // pulse comparison: which resets fired, how long, how many restore strobes
    task automatic chk_pulse(input logic [2:0] bits, input int w, input int nr);
        cmp_count++;
        if (seen !== bits || w_seen != w || n_restore != nr) begin
            n_mismatch++;
            $display("unexpected pulse: expected %b/%0d/%0d seen %b/%0d/%0d", bits, w, nr,
                     seen, w_seen, n_restore);
        end
        seen = 3'h0;
        w_seen = 0;
        n_restore = 0;
    endtask : chk_pulse
    // verdict
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    // watchdog sized at about four times the expected run
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        h.rd(STRAP, 8'h00, d, ack);
        chk("ack strap", 8'h01, {7'h00, ack});
        chk("addr boot", {STRAP, 1'b0}, d);
        h.rd(STRAP, 8'h01, d, ack);
        chk("rst boot", 8'h00, d);
        // two bytes in one read, the master ack between them fetches the byte at the next pointer
        h.rd_pair(STRAP, 8'h00, d, d2, ack);
        chk("pair addr", {STRAP, 1'b0}, d);
        chk("pair rst", 8'h00, d2);
        h.wr(BAD, 8'h00, 8'hFF, ack);
        chk("ack bad", 8'h00, {7'h00, ack});
        h.wr(STRAP, 8'h00, {PROG, 1'b0}, ack);
        h.rd(STRAP, 8'h00, d, ack);
        chk("addr sel0", {PROG, 1'b0}, d);
        h.wr(STRAP, 8'h00, {PROG, 1'b1}, ack);
        h.rd(STRAP, 8'h00, d, ack);
        chk("ack old", 8'h00, {7'h00, ack});
        h.rd(PROG, 8'h00, d, ack);
        chk("addr sel1", {PROG, 1'b1}, d);
        // video reset leaves the address register alone
        h.wr(PROG, 8'h01, 8'h10, ack);
        chk_pulse(3'b100, RST_CYC, 0);
        h.rd(PROG, 8'h01, d, ack);
        chk("video clear", 8'h00, d);
        h.rd(PROG, 8'h00, d, ack);
        chk("addr kept", {PROG, 1'b1}, d);
        // keep reset brings back the strap address
        h.wr(PROG, 8'h01, 8'h01, ack);
        chk_pulse(3'b001, RST_CYC, 1);
        h.rd(STRAP, 8'h00, d, ack);
        chk("addr keep", {STRAP, 1'b0}, d);
        h.rd(STRAP, 8'h01, d, ack);
        chk("keep clear", 8'h00, d);
        // full reset, then the host sets the bridge control restore bit
        h.wr(STRAP, 8'h00, {PROG, 1'b1}, ack);
        h.wr(PROG, 8'h01, 8'h02, ack);
        chk_pulse(3'b010, RST_CYC, 1);
        h.wr(STRAP, 8'h4F, 8'h02, ack);
        chk("ack full", 8'h01, {7'h00, ack});
        h.rd(STRAP, 8'h00, d, ack);
        chk("addr full", {STRAP, 1'b0}, d);
        h.rd(STRAP, 8'h01, d, ack);
        chk("full clear", 8'h00, d);
        // reserved bits fire nothing and read zero
        h.wr(STRAP, 8'h01, 8'hEC, ack);
        chk_pulse(3'b000, 0, 0);
        h.rd(STRAP, 8'h01, d, ack);
        chk("reserved", 8'h00, d);
        end_sim();
    end
endmodule : abr_top_tb_top
